// [logic/csp_pkg.sv]
// constants shared by the serial control port design files
// assumes a single 100 MHz clock and active-low asynchronous reset
//
// Notes on behaviour
// - squelch mode 0: pin high zeroes clock and data
// - squelch mode 1: high silences data, low clock
// - slave address 1, select pin, five zeros
// - address byte lsb 1 reads, 0 writes
// - start is data falling while clock high
// - eight bits per byte, msb first
// - ack ninth pulse on match, else idle
// - second byte is subaddress among eight registers
// - subaddress advances after each data byte, holding at the highest
// - stop anywhere returns to idle, start anywhere to address phase
// - bad subaddress: no ack, go idle
// - reads past top repeat highest register
// - lock where data/2^ratio equals ref/2^range
// - range field picks reference band, default 00
// - ratio field n gives multiple 2^n, n capped at 8
// - lost lock in reference mode forces relock
package csp_pkg;
    localparam int        NUM_REGS        = 8;
    localparam logic       ADDR_TOP_BIT    = 1'b1;
    localparam logic [4:0] ADDR_LOW_BITS   = 5'h00;
    localparam logic [2:0] SUB_STATUS      = 3'h0;
    localparam logic [2:0] SUB_REF_LOCK    = 3'h1;
    localparam logic [2:0] SUB_OUT_CFG     = 3'h2;
    localparam logic [2:0] SUB_TOP         = 3'h7;
    localparam logic [7:0] SUB_LIMIT       = 8'h08;
    localparam int        REF_LOCK_BIT    = 0;
    localparam int        REF_FINE_BIT    = 1;
    localparam int        REF_RATIO_LSB   = 2;
    localparam int        REF_RANGE_LSB   = 6;
    localparam int        OUT_SQ_MODE_BIT = 1;
    localparam logic [7:0] REF_LOCK_RESET  = 8'h00;
    localparam logic [7:0] OUT_CFG_RESET   = 8'h00;
    localparam logic [7:0] REG_RESET       = 8'h00;
    localparam logic [3:0] RATIO_MAX       = 4'h8;
    localparam logic [3:0] BIT_COUNT       = 4'h8;
endpackage

// [logic/csp_regfile.sv]
// eight byte registers of the control port, registered read port
// assumes one write port driven from the serial engine
`timescale 1ns/1ns
`default_nettype none
module csp_regfile
    import csp_pkg::*;
#(
    parameter int DEPTH = csp_pkg::NUM_REGS
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_wr_en,
    input  wire logic [2:0] i_wr_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic [2:0] i_rd_addr,
    output var  logic [7:0] o_rd_data,
    output var  logic [7:0] o_ref_lock_ctl,
    output var  logic [7:0] o_out_cfg_ctl
);
    logic [7:0] mem_reg [DEPTH];

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= REG_RESET;
            end
            mem_reg[SUB_REF_LOCK] <= REF_LOCK_RESET;
            mem_reg[SUB_OUT_CFG]  <= OUT_CFG_RESET;
            o_rd_data             <= REG_RESET;
        end else begin
            if (i_wr_en) begin
                mem_reg[i_wr_addr] <= i_wr_data;
            end
            o_rd_data <= mem_reg[i_rd_addr];
        end
    end

    assign o_ref_lock_ctl = mem_reg[SUB_REF_LOCK];
    assign o_out_cfg_ctl  = mem_reg[SUB_OUT_CFG];
endmodule
`default_nettype wire

// [logic/csp_sync.sv]
// two-flop synchroniser for a group of asynchronous levels
// assumes each bit is an independent level; no word coherence
`timescale 1ns/1ns
`default_nettype none
module csp_sync #(
    parameter int               WIDTH     = 1,
    // idle level per bit, so no false edge follows reset
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_resetn,
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_reg <= RESET_VAL;
            o_sync   <= RESET_VAL;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// [logic/csp_top.sv]
// serial control port of a clock and data recovery receiver
// assumes bus lines, squelch, recovered signals and lock status arrive
// asynchronously and are sampled by the 100 MHz reference clock
`timescale 1ns/1ns
`default_nettype none
module csp_top
    import csp_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output var  logic       o_sda_out,
    output var  logic       o_sda_oe,
    input  wire logic       i_address_select_pin,
    input  wire logic       i_squelch,
    input  wire logic       i_recovered_clock,
    input  wire logic       i_recovered_data,
    input  wire logic       i_lock_lost,
    output var  logic       o_recovered_clock_out,
    output var  logic       o_recovered_data_out,
    output var  logic       o_ref_lock_enable,
    output var  logic       o_fine_rate_enable,
    output var  logic [1:0] o_ref_range,
    output var  logic [8:0] o_ref_ratio_mult,
    output var  logic       o_ref_restart,
    output var  logic       o_ref_relock
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
        ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } csp_state_t;

    function automatic logic [2:0] sat_inc(input logic [2:0] p);
        sat_inc = (p == SUB_TOP) ? SUB_TOP : p + 3'h1;
    endfunction

    function automatic logic [8:0] pow2(input logic [3:0] n);
        logic [3:0] k;
        k = (n > RATIO_MAX) ? RATIO_MAX : n;
        pow2 = 9'h001 << k;
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic [6:0] sync_out;
    logic       scl_s;
    logic       sda_s;
    logic       sel_s;
    logic       sq_s;
    logic       rclk_s;
    logic       rdat_s;
    logic       lost_s;

    // bus clock and data reset to their idle high level
    csp_sync #(.WIDTH(7), .RESET_VAL(7'h60)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_async   ({i_scl, i_sda, i_address_select_pin, i_squelch,
                     i_recovered_clock, i_recovered_data, i_lock_lost}),
        .o_sync    (sync_out)
    );
    assign {scl_s, sda_s, sel_s, sq_s, rclk_s, rdat_s, lost_s} = sync_out;

    ////////////////////////////////////////////////////////////////////
    csp_state_t state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [2:0] ptr_reg, ptr_next;
    logic       oe_reg, oe_next;
    logic       rw_reg, rw_next;
    logic       scl_q, sda_q;
    logic       wr_en;
    logic [7:0] rf_rd_data;
    logic [7:0] rd_data;
    logic [7:0] ref_ctl;
    logic [7:0] out_cfg;
    logic [7:0] status;
    logic [6:0] my_addr;
    logic       scl_rise, scl_fall, start_c, stop_c;
    logic       byte_done;

    csp_regfile u_regs (
        .i_ref_clk      (i_ref_clk),
        .i_resetn       (i_resetn),
        .i_wr_en        (wr_en),
        .i_wr_addr      (ptr_reg),
        .i_wr_data      (shift_reg),
        .i_rd_addr      (ptr_reg),
        .o_rd_data      (rf_rd_data),
        .o_ref_lock_ctl (ref_ctl),
        .o_out_cfg_ctl  (out_cfg)
    );

    // status register is live state, not storage
    assign status  = {5'h00, o_ref_relock, lost_s, o_ref_lock_enable};
    assign rd_data = (ptr_reg == SUB_STATUS) ? status : rf_rd_data;

    assign my_addr   = {ADDR_TOP_BIT, sel_s, ADDR_LOW_BITS};
    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign start_c   = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_c    = scl_s & scl_q & ~sda_q & sda_s;
    assign byte_done = scl_fall && (cnt_reg == BIT_COUNT);

    // bits are sampled on the rising clock edge and the line is only
    // changed after a falling edge, so setup to the master is half a bit
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        ptr_next   = ptr_reg;
        oe_next    = oe_reg;
        rw_next    = rw_reg;
        wr_en      = 1'b0;
        if (stop_c) begin
            state_next = ST_IDLE;
            oe_next    = 1'b0;
        end else if (start_c) begin
            state_next = ST_ADDR;
            cnt_next   = 4'h0;
            oe_next    = 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    oe_next = 1'b0;
                end
                ST_ADDR, ST_SUB, ST_WR: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        cnt_next = 4'h0;
                        if (state_reg == ST_ADDR) begin
                            if (shift_reg[7:1] == my_addr) begin
                                oe_next    = 1'b1;
                                rw_next    = shift_reg[0];
                                state_next = ST_ADDR_ACK;
                            end else begin
                                state_next = ST_IDLE;
                            end
                        end else if (state_reg == ST_SUB) begin
                            if (shift_reg < SUB_LIMIT) begin
                                ptr_next   = shift_reg[2:0];
                                oe_next    = 1'b1;
                                state_next = ST_SUB_ACK;
                            end else begin
                                state_next = ST_IDLE;
                            end
                        end else begin
                            wr_en      = 1'b1;
                            oe_next    = 1'b1;
                            state_next = ST_WR_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_next = 4'h0;
                        if (rw_reg) begin
                            shift_next = rd_data;
                            oe_next    = ~rd_data[7];
                            state_next = ST_RD;
                        end else begin
                            oe_next    = 1'b0;
                            state_next = ST_SUB;
                        end
                    end
                end
                ST_SUB_ACK: begin
                    if (scl_fall) begin
                        oe_next    = 1'b0;
                        cnt_next   = 4'h0;
                        state_next = ST_WR;
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        oe_next    = 1'b0;
                        cnt_next   = 4'h0;
                        ptr_next   = sat_inc(ptr_reg);
                        state_next = ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], 1'b0};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        oe_next    = 1'b0;
                        cnt_next   = 4'h0;
                        state_next = ST_RD_ACK;
                    end else if (scl_fall) begin
                        oe_next = ~shift_reg[7];
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state_next = ST_IDLE;
                        end else begin
                            ptr_next = sat_inc(ptr_reg);
                        end
                    end else if (scl_fall) begin
                        shift_next = rd_data;
                        oe_next    = ~rd_data[7];
                        state_next = ST_RD;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    oe_next    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg   <= 3'h0;
            oe_reg    <= 1'b0;
            rw_reg    <= 1'b0;
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            o_sda_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg   <= ptr_next;
            oe_reg    <= oe_next;
            rw_reg    <= rw_next;
            scl_q     <= scl_s;
            sda_q     <= sda_s;
            o_sda_out <= 1'b0; // open drain: only ever pulls low
        end
    end
    assign o_sda_oe = oe_reg;

    ////////////////////////////////////////////////////////////////////
    logic clk_out_next, dat_out_next;
    logic lock_q;
    logic restart_next, relock_next;

    always_comb begin
        clk_out_next = rclk_s;
        dat_out_next = rdat_s;
        if (!out_cfg[OUT_SQ_MODE_BIT]) begin
            if (sq_s) begin
                clk_out_next = 1'b0;
                dat_out_next = 1'b0;
            end
        end else if (sq_s) begin
            dat_out_next = 1'b0;
        end else begin
            clk_out_next = 1'b0;
        end
        restart_next = ref_ctl[REF_LOCK_BIT] & ~lock_q;
        // relock request held while reference lock mode sees lost lock
        relock_next  = ref_ctl[REF_LOCK_BIT] & lost_s;
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_recovered_clock_out <= 1'b0;
            o_recovered_data_out  <= 1'b0;
            o_ref_lock_enable     <= 1'b0;
            o_fine_rate_enable    <= 1'b0;
            o_ref_range           <= 2'b00;
            o_ref_ratio_mult      <= 9'h001;
            o_ref_restart         <= 1'b0;
            o_ref_relock          <= 1'b0;
            lock_q                <= 1'b0;
        end else begin
            o_recovered_clock_out <= clk_out_next;
            o_recovered_data_out  <= dat_out_next;
            o_ref_lock_enable     <= ref_ctl[REF_LOCK_BIT];
            // both bits set is unsupported; passed through as written
            o_fine_rate_enable    <= ref_ctl[REF_FINE_BIT];
            o_ref_range <= ref_ctl[REF_RANGE_LSB +: 2];
            o_ref_ratio_mult <= pow2(ref_ctl[REF_RATIO_LSB +: 4]);
            o_ref_restart         <= restart_next;
            o_ref_relock          <= relock_next;
            lock_q                <= ref_ctl[REF_LOCK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    squelch_and_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (!out_cfg[OUT_SQ_MODE_BIT] && sq_s) |=>
            (!o_recovered_clock_out && !o_recovered_data_out))
        else $error("squelch mode 0 left an output active");

    squelch_or_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_resetn)
        out_cfg[OUT_SQ_MODE_BIT] |=>
            ($past(sq_s) ? (!o_recovered_data_out &&
                            o_recovered_clock_out == $past(rclk_s))
                         : (!o_recovered_clock_out &&
                            o_recovered_data_out == $past(rdat_s))))
        else $error("squelch mode 1 silenced the wrong output");

    addr_ack_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_reg == ST_ADDR && byte_done && !start_c && !stop_c &&
         shift_reg[7:1] == {1'b1, sel_s, 5'h00}) |=>
            (o_sda_oe && state_reg == ST_ADDR_ACK))
        else $error("matching address was not acknowledged");

    ack_hold_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_reg == ST_ADDR_ACK && !scl_fall && !start_c && !stop_c) |=>
            (o_sda_oe && state_reg == ST_ADDR_ACK))
        else $error("address ack released before the clock fell");

    addr_nack_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_reg == ST_ADDR && byte_done && !start_c && !stop_c &&
         shift_reg[7:1] != my_addr) |=>
            (state_reg == ST_IDLE && !o_sda_oe)[*2])
        else $error("foreign address did not leave the bus");

    bad_sub_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_reg == ST_SUB && byte_done && !start_c && !stop_c &&
         shift_reg >= SUB_LIMIT) |=> (state_reg == ST_IDLE && !o_sda_oe))
        else $error("invalid subaddress was acknowledged");

    stop_idle_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_resetn)
        stop_c |=> (state_reg == ST_IDLE && !o_sda_oe))
        else $error("stop did not return the port to idle");

    rd_sat_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_reg == ST_RD_ACK && scl_rise && !sda_s &&
         ptr_reg == SUB_TOP && !start_c && !stop_c) |=> ptr_reg == SUB_TOP)
        else $error("read pointer left the highest register");

    wr_inc_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_reg == ST_WR_ACK && scl_fall && ptr_reg != SUB_TOP &&
         !start_c && !stop_c) |=> ptr_reg == $past(ptr_reg) + 3'h1)
        else $error("subaddress did not advance after a byte");

    idle_release_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_reg == ST_IDLE || state_reg == ST_SUB ||
         state_reg == ST_WR) |-> !o_sda_oe || $past(state_reg) != state_reg)
        else $error("data line driven outside ack or read");

    restart_pulse_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_resetn)
        $rose(ref_ctl[REF_LOCK_BIT]) |=> o_ref_restart ##1 !o_ref_restart)
        else $error("lock enable edge gave no single restart pulse");
endmodule
`default_nettype wire

// [verif/csp_bus_master.sv]
// two-wire bus master model facing the serial control port
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ns
`default_nettype none
module csp_bus_master (
    input  wire logic i_sda_wire,
    output var  logic o_scl,
    output var  logic o_sda_low
);
    localparam int QTR  = 31;
    localparam int QTRB = 32;
    localparam int HALF = 62;

    // clock parks high between frames
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // long low phase first: the slave may still hold its ack for ~30 ns
    task automatic start();
        o_sda_low = 1'b0;
        #HALF o_scl = 1'b1;
        #HALF o_sda_low = 1'b1;
        #HALF o_scl = 1'b0;
    endtask

    task automatic stop();
        o_sda_low = 1'b1;
        #HALF o_scl = 1'b1;
        #HALF o_sda_low = 1'b0;
        #HALF;
    endtask

    task automatic xbit(input logic b, output logic r);
        #QTR o_sda_low = ~b;
        #QTRB o_scl = 1'b1;
        r = i_sda_wire;
        #HALF o_scl = 1'b0;
    endtask

    // reads pass 8'hff so the line stays released for the slave
    task automatic xbyte(input logic [7:0] d, input logic a,
                         output logic [7:0] q, output logic r);
        for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
        xbit(a, r);
    endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the serial control port
// assumes csp_bus_master drives the bus pins of the design
`timescale 1ns/1ns
`default_nettype none
module tb;
    import csp_pkg::*;
    logic       clk, rst_n, sel, sq, rc, rd, lost;
    logic       scl, sda_low, sda_out, sda_oe, rco, rdo;
    logic       lock_en, fine_en, restart, relock, ack, bit0;
    logic [1:0] range;
    logic [8:0] mult, e;
    logic [7:0] rb [8];
    logic [7:0] wb [8];
    logic [7:0] q, v;
    int         bad_count = 0;
    int         samples_checked = 0;
    int         restarts = 0;
    int         exp_restarts = 0;
    wire  logic sda = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);

    csp_top dut (
        .i_ref_clk(clk), .i_resetn(rst_n), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_address_select_pin(sel), .i_squelch(sq),
        .i_recovered_clock(rc), .i_recovered_data(rd),
        .i_lock_lost(lost), .o_recovered_clock_out(rco),
        .o_recovered_data_out(rdo), .o_ref_lock_enable(lock_en),
        .o_fine_rate_enable(fine_en), .o_ref_range(range),
        .o_ref_ratio_mult(mult), .o_ref_restart(restart),
        .o_ref_relock(relock)
    );
    csp_bus_master mst (.i_sda_wire(sda), .o_scl(scl), .o_sda_low(sda_low));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // restart is a one-cycle pulse, so it is counted, not polled
    always @(negedge clk) if (restart === 1'b1) restarts++;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [8:0] x,
                       input logic [8:0] g);
        samples_checked++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic finish_test();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] dev_addr(input logic rw);
        return {ADDR_TOP_BIT, sel, ADDR_LOW_BITS, rw};
    endfunction

    function automatic logic [1:0] sq_exp(input logic m, input logic s,
                                          input logic c, input logic d);
        if (!m) return s ? 2'b00 : {c, d};
        return s ? {c, 1'b0} : {1'b0, d};
    endfunction

    task automatic head(input logic [7:0] sub);
        mst.start();
        mst.xbyte(dev_addr(1'b0), 1'b1, q, ack);
        chk("addr ack", 9'h0, {8'h0, ack});
        mst.xbyte(sub, 1'b1, q, ack);
        chk("sub ack", 9'h0, {8'h0, ack});
    endtask

    task automatic wr(input logic [7:0] sub, input int n);
        head(sub);
        for (int i = 0; i < n; i++) begin
            mst.xbyte(wb[i], 1'b1, q, ack);
            chk("data ack", 9'h0, {8'h0, ack});
        end
        mst.stop();
    endtask

    task automatic rd_burst(input logic [7:0] sub, input int n);
        head(sub);
        mst.start();
        mst.xbyte(dev_addr(1'b1), 1'b1, q, ack);
        chk("read ack", 9'h0, {8'h0, ack});
        for (int i = 0; i < n; i++) mst.xbyte(8'hff, i == n - 1, rb[i], ack);
        mst.stop();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, sel, sq, rc, rd, lost} = 6'h00;
        v = 8'($urandom(32'he7f1d095));
        bit0 = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        chk("ratio reset", 9'h001, mult);
        rd_burst(8'h00, 8);
        for (int i = 0; i < 8; i++) chk("reg reset", 9'h0, {1'b0, rb[i]});
        for (int k = 0; k < 24; k++) begin
            @(negedge clk) sel = 1'($urandom);
            v = 8'($urandom);
            if (v[0]) v[1] = 1'b0;
            v[7:6] = 2'(k);
            if (k < 16) v[5:2] = 4'(k);
            if (bit0) begin
                wb[0] = v & 8'hfe;
                wr(8'h01, 1);
            end
            exp_restarts += int'(v[0]);
            bit0 = v[0];
            wb[0] = v;
            wb[1] = {6'h00, 1'($urandom), 1'b0};
            wr(8'h01, 2);
            e = (v[5:2] > RATIO_MAX) ? 9'h100 : 9'h001 << v[5:2];
            chk("ratio", e, mult);
            chk("range", {7'h0, v[7:6]}, {7'h0, range});
            chk("lock", {8'h0, v[0]}, {8'h0, lock_en});
            chk("fine", {8'h0, v[1]}, {8'h0, fine_en});
            for (int j = 0; j < 4; j++) begin
                @(negedge clk) {sq, rc, rd} = 3'($urandom);
                repeat (4) @(negedge clk);
                chk("squelch", {7'h0, sq_exp(wb[1][1], sq, rc, rd)},
                    {7'h0, rco, rdo});
            end
        end
        wb[0] = 8'h00;
        wr(8'h01, 1);
        wb[0] = 8'h01;
        wr(8'h01, 1);
        exp_restarts++;
        chk("restarts", 9'(exp_restarts), 9'(restarts));
        @(negedge clk) lost = 1'b1;
        repeat (6) @(negedge clk);
        chk("relock", 9'h001, {8'h0, relock});
        rd_burst(8'h00, 1);
        chk("status", 9'h007, {1'b0, rb[0]});
        @(negedge clk) lost = 1'b0;
        repeat (6) @(negedge clk);
        chk("relock off", 9'h000, {8'h0, relock});
        for (int i = 0; i < 5; i++) wb[i] = 8'($urandom);
        wr(8'h03, 5);
        rd_burst(8'h03, 7);
        for (int i = 0; i < 7; i++)
            chk("autoinc", {1'b0, wb[(i > 4) ? 4 : i]}, {1'b0, rb[i]});
        for (int j = 0; j < 3; j++) begin
            v = dev_addr(1'b0) ^ ((j == 0) ? 8'h80 : (j == 1) ? 8'h40 :
                8'(8'h02 << ($urandom % 5)));
            mst.start();
            mst.xbyte(v, 1'b1, q, ack);
            chk("bad addr", 9'h001, {8'h0, ack});
            mst.stop();
        end
        mst.start();
        mst.xbyte(dev_addr(1'b0), 1'b1, q, ack);
        mst.xbyte(8'(SUB_LIMIT + $urandom % 248), 1'b1, q, ack);
        chk("bad sub", 9'h001, {8'h0, ack});
        mst.stop();
        v = dev_addr(1'b0);
        mst.start();
        for (int i = 0; i < 3; i++) mst.xbit(v[7 - i], ack);
        mst.stop();
        wb[0] = 8'h5a;
        wr(8'h04, 1);
        rd_burst(8'h04, 1);
        chk("after abort", 9'h05a, {1'b0, rb[0]});
        finish_test();
    end

    // cuts a hang short well inside the cycle budget
    initial begin
        #900000;
        bad_count++;
        finish_test();
    end
endmodule
`default_nettype wire
